// ==== rtl/jri_map.vh ====
// Constants of the tap-driven RAM initialisation loader
`ifndef JRI_MAP_VH
`define JRI_MAP_VH

// ==========================================================
// Widths
`define JRI_WORD_W 4
`define JRI_ADDR_W 2
`define JRI_IR_W 8
`define JRI_BLOCKS 4
`define JRI_FIFO_DEPTH 16
`define JRI_FIFO_AW 4
`define JRI_ADDR_LAST 2'h3
`define JRI_BITCNT_W 3

// ==========================================================
// Instruction opcodes
`define JRI_OP_START 8'h22
`define JRI_OP_ADDR 8'h24
`define JRI_OP_BLK_BASE 6'h0c
`define JRI_OP_BLK_HI 7:2
`define JRI_OP_BLK_LO 1:0

// ==========================================================
// Block selection modes
`define JRI_SEL_COMMON 2'h0
`define JRI_SEL_RING 2'h1
`define JRI_SEL_OPCODE 2'h2

// ==========================================================
// Reset values
`define JRI_RING_INIT 4'h1
`define JRI_ADDR_INIT 2'h0

// ==========================================================
// Write clock timing
`define JRI_CLK_NS 100
`define JRI_SETUP_NS 200
`define JRI_HOLD_NS 200
`define JRI_SETUP_CYC ((`JRI_SETUP_NS + `JRI_CLK_NS - 1) / `JRI_CLK_NS)
`define JRI_HOLD_CYC ((`JRI_HOLD_NS + `JRI_CLK_NS - 1) / `JRI_CLK_NS)
`define JRI_TCNT_W 4

`endif

// ==== rtl/jri_fifo.v ====
// Word FIFO between the serial loader and the RAM write engine
module jri_fifo #(
    parameter W = 4,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

// ==========================================================
// Storage and pointers
localparam integer FULL_INT = DEPTH;
localparam [AW:0] FULL = FULL_INT[AW:0];

reg [W-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;

wire push = in_valid & in_ready;
wire pop = out_valid & out_ready;

assign in_ready = (count != FULL);
assign out_valid = (count != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr];

always @(posedge clk) begin
    if (push) begin
        mem[wr_ptr] <= in_data;
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
    end else if (flush) begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
        if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
end

endmodule // jri_fifo

// ==== rtl/jri_loader.v ====
// Loader that writes tap-shifted words into on-chip RAM blocks
// How it works
// - Tap command, data and clock are synchronised, then written to the right RAM block.
// - Each RAM block has its own chip select output.
// - Serial data from the tap is presented as a parallel write word.
// - Our write clock frames data, address and chip select for the RAMs.
// - The shift register is exactly one RAM word wide.
// - Bits are shifted on rising edges of the tap data-register clock.
// - Only whole words go on; a word FIFO queues them for alignment with address and clock.
// - Address comes from a host address opcode or from the internal counter.
// - The internal counter sweeps the address range; host only shifts data.
// - Common mode enables every block at once for identical contents.
// - Opcode mode picks one block per distinct instruction opcode.
// - Ring mode advances the block select once past a block's last address.
// - Shifting happens only while the shift strobe is high.
// - Counters and selects follow comparison of the instruction with the start opcode and, in opcode mode, with the block opcodes.
// - A matching opcode starts addressing and enables the selected blocks.
// - A rising update strobe marks one completely loaded word.
// - After update, data and its matching address appear on the outputs.
// - Write clock is low while data settles, then rises to capture.
// - Falling-edge option drives the write clock inverted.
// - The RAM write ports are driven only by this block, keyed by the instruction.
`include "jri_map.vh"

module jri_loader (
    input wire core_clk,
    input wire arst_n,
    input wire user_dr_clock,
    input wire user_serial_data_in,
    input wire user_dr_shift_strobe,
    input wire user_dr_update_strobe,
    input wire [`JRI_IR_W-1:0] user_instruction_value,
    input wire [1:0] select_mode,
    input wire wr_clk_falling,
    output reg [`JRI_WORD_W-1:0] ram_wr_data,
    output reg [`JRI_ADDR_W-1:0] ram_wr_addr,
    output reg [`JRI_BLOCKS-1:0] ram_chip_sel,
    output reg [`JRI_BLOCKS-1:0] ram_wr_en,
    output reg ram_wr_clk,
    output reg load_ready,
    output reg init_active
);

// ==========================================================
// Constants
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_SETUP = 3'b010;
localparam [2:0] ST_STROBE = 3'b100;
localparam integer SETUP_INT = `JRI_SETUP_CYC;
localparam integer HOLD_INT = `JRI_HOLD_CYC;
localparam integer WORD_INT = `JRI_WORD_W;
localparam [`JRI_TCNT_W-1:0] SETUP_CYC = SETUP_INT[`JRI_TCNT_W-1:0];
localparam [`JRI_TCNT_W-1:0] HOLD_CYC = HOLD_INT[`JRI_TCNT_W-1:0];
localparam [`JRI_BITCNT_W-1:0] WORD_BITS = WORD_INT[`JRI_BITCNT_W-1:0];

function [`JRI_BLOCKS-1:0] blk_onehot;
    input [1:0] idx;
    begin
        blk_onehot = {{(`JRI_BLOCKS-1){1'b0}}, 1'b1} << idx;
    end
endfunction

// ==========================================================
// Reset release
reg rst_meta;
reg rst_n;

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        rst_meta <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n <= rst_meta;
    end
end

// ==========================================================
// Pin synchronisers
// IR bits may cross with skew; the tap only changes them at
// instruction update, so a one-cycle mismatch is harmless.
localparam PIN_W = 4 + `JRI_IR_W + 3;

reg [PIN_W-1:0] pin_meta;
reg [PIN_W-1:0] pin_sync;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        pin_meta <= {PIN_W{1'b0}};
        pin_sync <= {PIN_W{1'b0}};
    end else begin
        pin_meta <= {wr_clk_falling, select_mode, user_instruction_value,
                     user_dr_update_strobe, user_dr_shift_strobe,
                     user_serial_data_in, user_dr_clock};
        pin_sync <= pin_meta;
    end
end

wire dr_clk_s = pin_sync[0];
wire sdi_s = pin_sync[1];
wire shift_s = pin_sync[2];
wire update_s = pin_sync[3];
wire [`JRI_IR_W-1:0] ir_s = pin_sync[4 +: `JRI_IR_W];
wire [1:0] mode_s = pin_sync[4 + `JRI_IR_W +: 2];
wire falling_s = pin_sync[PIN_W-1];

// ==========================================================
// Edge detection and instruction decode
reg dr_clk_prev;
reg update_prev;
reg active_prev;
reg [`JRI_IR_W-1:0] ir_prev;

wire dr_rise = dr_clk_s & ~dr_clk_prev;
wire upd_rise = update_s & ~update_prev;
wire mode_ring = (mode_s == `JRI_SEL_RING);
wire mode_opc = (mode_s == `JRI_SEL_OPCODE);
wire ir_start = (ir_s == `JRI_OP_START);
wire ir_addr = (ir_s == `JRI_OP_ADDR);
wire ir_blk = mode_opc && (ir_s[`JRI_OP_BLK_HI] == `JRI_OP_BLK_BASE);
wire active = ir_start | ir_blk;
wire new_load = active & (~active_prev | (ir_s != ir_prev));

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        dr_clk_prev <= 1'b0;
        update_prev <= 1'b0;
        active_prev <= 1'b0;
        ir_prev <= {`JRI_IR_W{1'b0}};
    end else begin
        dr_clk_prev <= dr_clk_s;
        update_prev <= update_s;
        active_prev <= active;
        ir_prev <= ir_s;
    end
end

// ==========================================================
// Serial shift registers
reg [`JRI_WORD_W-1:0] data_sh;
reg [`JRI_ADDR_W-1:0] addr_sh;
reg [`JRI_BITCNT_W-1:0] bit_cnt;

wire shift_now = dr_rise & shift_s;
wire word_full = (bit_cnt == WORD_BITS);

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        data_sh <= {`JRI_WORD_W{1'b0}};
        addr_sh <= {`JRI_ADDR_W{1'b0}};
        bit_cnt <= {`JRI_BITCNT_W{1'b0}};
    end else begin
        if (shift_now && active) begin
            data_sh <= {sdi_s, data_sh[`JRI_WORD_W-1:1]};
            if (!word_full) begin
                bit_cnt <= bit_cnt + 1'b1;
            end
        end else if (upd_rise) begin
            bit_cnt <= {`JRI_BITCNT_W{1'b0}};
        end
        if (shift_now && ir_addr) begin
            addr_sh <= {sdi_s, addr_sh[`JRI_ADDR_W-1:1]};
        end
    end
end

// ==========================================================
// Word FIFO
// A word is kept only if all its bits arrived since the last
// update; a partial scan is discarded rather than written.
wire fifo_in_ready;
wire fifo_out_valid;
wire fifo_out_ready;
wire [`JRI_WORD_W-1:0] fifo_out_data;
wire push = upd_rise & active & word_full;
wire flush = new_load | ~active;

jri_fifo #(
    .W(`JRI_WORD_W),
    .DEPTH(`JRI_FIFO_DEPTH),
    .AW(`JRI_FIFO_AW)
) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(data_sh),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
);

// ==========================================================
// Address counter and block select
reg [`JRI_ADDR_W-1:0] addr;
reg [`JRI_BLOCKS-1:0] ring;
reg [2:0] state;
reg [`JRI_TCNT_W-1:0] tcnt;

wire write_done = (state == ST_STROBE) && (tcnt == HOLD_CYC);
reg [`JRI_BLOCKS-1:0] cs_sel;

always @* begin
    case (mode_s)
        `JRI_SEL_RING: cs_sel = ring;
        `JRI_SEL_OPCODE: cs_sel = blk_onehot(ir_s[`JRI_OP_BLK_LO]);
        default: cs_sel = {`JRI_BLOCKS{1'b1}};
    endcase
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        addr <= `JRI_ADDR_INIT;
        ring <= `JRI_RING_INIT;
    end else if (new_load) begin
        // A host-loaded address survives the step to a data opcode
        if (ir_prev != `JRI_OP_ADDR) begin
            addr <= `JRI_ADDR_INIT;
        end
        ring <= `JRI_RING_INIT;
    end else if (upd_rise && ir_addr) begin
        addr <= addr_sh;
    end else if (write_done) begin
        addr <= addr + 1'b1;
        if (mode_ring && addr == `JRI_ADDR_LAST) begin
            ring <= {ring[`JRI_BLOCKS-2:0], ring[`JRI_BLOCKS-1]};
        end
    end
end

// ==========================================================
// Write engine
// Our own write clock replaces the update strobe so that words
// buffered in the FIFO still get a full settle time each.
wire settle_lvl = falling_s;
assign fifo_out_ready = (state == ST_IDLE) && active;

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        tcnt <= {`JRI_TCNT_W{1'b0}};
        ram_wr_data <= {`JRI_WORD_W{1'b0}};
        ram_wr_addr <= {`JRI_ADDR_W{1'b0}};
        ram_chip_sel <= {`JRI_BLOCKS{1'b0}};
        ram_wr_en <= {`JRI_BLOCKS{1'b0}};
        ram_wr_clk <= 1'b1;
    end else begin
        case (state)
            ST_IDLE: begin
                ram_wr_en <= {`JRI_BLOCKS{1'b0}};
                ram_wr_clk <= ~settle_lvl;
                tcnt <= {`JRI_TCNT_W{1'b0}};
                if (active) begin
                    ram_chip_sel <= cs_sel;
                end else begin
                    ram_chip_sel <= {`JRI_BLOCKS{1'b0}};
                end
                if (fifo_out_valid && active) begin
                    ram_wr_data <= fifo_out_data;
                    ram_wr_addr <= addr;
                    ram_chip_sel <= cs_sel;
                    ram_wr_en <= cs_sel;
                    ram_wr_clk <= settle_lvl;
                    state <= ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (tcnt == SETUP_CYC - 1'b1) begin
                    ram_wr_clk <= ~settle_lvl;
                    tcnt <= {`JRI_TCNT_W{1'b0}};
                    state <= ST_STROBE;
                end else begin
                    tcnt <= tcnt + 1'b1;
                end
            end
            ST_STROBE: begin
                if (write_done) begin
                    ram_wr_en <= {`JRI_BLOCKS{1'b0}};
                    state <= ST_IDLE;
                end else begin
                    tcnt <= tcnt + 1'b1;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

// ==========================================================
// Status outputs
// The tap cannot be stalled; load_ready low means the host must
// slow its scans or words are dropped.
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        load_ready <= 1'b0;
        init_active <= 1'b0;
    end else begin
        load_ready <= fifo_in_ready & active;
        init_active <= active;
    end
end

endmodule // jri_loader

// ==== bench/jri_loader_checker.sv ====
// Port-level assertions for the tap-driven RAM loader
`include "jri_map.vh"
// ==========================================================
// Checker
module jri_loader_checker (
    input wire core_clk,
    input wire arst_n,
    input wire [1:0] select_mode,
    input wire wr_clk_falling,
    input wire [`JRI_WORD_W-1:0] ram_wr_data,
    input wire [`JRI_ADDR_W-1:0] ram_wr_addr,
    input wire [`JRI_BLOCKS-1:0] ram_chip_sel,
    input wire [`JRI_BLOCKS-1:0] ram_wr_en,
    input wire ram_wr_clk,
    input wire init_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic en_q;
    logic had_write;
    logic [1:0] last_addr;
    logic [3:0] last_cs;
    // Remembers the previous write so the next one can be judged against it
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= 1'b0;
            had_write <= 1'b0;
            last_addr <= 2'h0;
            last_cs <= 4'h0;
        end else begin
            en_q <= |ram_wr_en;
            if (!init_active) begin
                had_write <= 1'b0;
            end else if ((|ram_wr_en) && !en_q) begin
                had_write <= 1'b1;
                last_addr <= ram_wr_addr;
                last_cs <= ram_chip_sel;
            end
        end
    end
    sequence s_low_settle;
        !ram_wr_clk [*2] ##1 ram_wr_clk;
    endsequence
    sequence s_high_settle;
        ram_wr_clk [*2] ##1 !ram_wr_clk;
    endsequence
    sequence s_hold;
        // Enable stands through three cycles after the capture edge
        (|ram_wr_en) [*3] ##1 (ram_wr_en == 4'h0);
    endsequence
    property p_unarmed;
        !init_active [*2] |-> ram_wr_en == 4'h0;
    endproperty
    property p_settle_rise;
        $rose(|ram_wr_en) && !wr_clk_falling |-> s_low_settle;
    endproperty
    property p_settle_fall;
        $rose(|ram_wr_en) && wr_clk_falling |-> s_high_settle;
    endproperty
    property p_hold;
        (wr_clk_falling ? $fell(ram_wr_clk) : $rose(ram_wr_clk)) && (|ram_wr_en) |-> s_hold;
    endproperty
    property p_stable;
        (|ram_wr_en) && $past(|ram_wr_en) |->
            $stable(ram_wr_data) && $stable(ram_wr_addr) && $stable(ram_chip_sel);
    endproperty
    property p_common;
        (|ram_wr_en) && select_mode == `JRI_SEL_COMMON |-> ram_wr_en == 4'hf;
    endproperty
    property p_select;
        (|ram_wr_en) |-> ram_wr_en == ram_chip_sel
            && (select_mode == `JRI_SEL_COMMON || $onehot(ram_wr_en));
    endproperty
    property p_step;
        $rose(|ram_wr_en) && had_write |-> ram_wr_addr == last_addr + 2'h1;
    endproperty
    property p_ring;
        $rose(|ram_wr_en) && had_write && select_mode == `JRI_SEL_RING |->
            ram_chip_sel == (last_addr == 2'h3 ? {last_cs[2:0], last_cs[3]} : last_cs);
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("write enable without opcode");
    a_settle_rise: assert property (p_settle_rise) else $error("bad low settle");
    a_settle_fall: assert property (p_settle_fall) else $error("bad high settle");
    a_hold: assert property (p_hold) else $error("enable hold wrong");
    a_stable: assert property (p_stable) else $error("outputs moved in write");
    a_common: assert property (p_common) else $error("common mode not all blocks");
    a_select: assert property (p_select) else $error("enable and select differ");
    a_step: assert property (p_step) else $error("address did not step");
    a_ring: assert property (p_ring) else $error("ring select wrong");
endmodule // jri_loader_checker

bind jri_loader jri_loader_checker u_chk (.core_clk(core_clk), .arst_n(arst_n),
    .select_mode(select_mode), .wr_clk_falling(wr_clk_falling), .ram_wr_data(ram_wr_data),
    .ram_wr_addr(ram_wr_addr), .ram_chip_sel(ram_chip_sel), .ram_wr_en(ram_wr_en),
    .ram_wr_clk(ram_wr_clk), .init_active(init_active));

// ==== bench/jri_ram_model.sv ====
// Behavioural RAM write port that reports every captured write
// ==========================================================
// RAM model
module jri_ram_model (
    input wire core_clk,
    input wire falling,
    input wire wr_clk,
    input wire [3:0] wr_en,
    input wire [1:0] addr,
    input wire [3:0] data,
    output logic got,
    output logic [9:0] rec
);
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_q = 1'b1;
    // Oversampled, so a capture shows one core cycle late; fine for checking
    always @(posedge core_clk) begin
        clk_q <= wr_clk;
        got <= 1'b0;
        if ((falling ? (clk_q && !wr_clk) : (!clk_q && wr_clk)) && (|wr_en)) begin
            got <= 1'b1;
            rec <= {wr_en, addr, data};
        end
    end
endmodule // jri_ram_model

// ==== bench/jri_loader_tb.sv ====
// Self-checking bench for the tap-driven RAM loader
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH %0t %s got %h exp %h", $time, m, a, e); end end
// ==========================================================
// Bench
module jri_loader_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic arst_n, dr_clk, sdi, shift, upd, falling, wclk, ready, active, got;
    logic [7:0] ir;
    logic [1:0] mode, emode, eaddr, blk, waddr;
    logic [3:0] wdata, cs, en, ering;
    logic [9:0] rec, exp_rec;
    logic [9:0] notes[$];
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    always #50 core_clk = ~core_clk;
    jri_loader u_dut (.core_clk(core_clk), .arst_n(arst_n), .user_dr_clock(dr_clk),
        .user_serial_data_in(sdi), .user_dr_shift_strobe(shift), .user_dr_update_strobe(upd),
        .user_instruction_value(ir), .select_mode(mode), .wr_clk_falling(falling),
        .ram_wr_data(wdata), .ram_wr_addr(waddr), .ram_chip_sel(cs), .ram_wr_en(en),
        .ram_wr_clk(wclk), .load_ready(ready), .init_active(active));
    jri_ram_model u_ram (.core_clk(core_clk), .falling(falling), .wr_clk(wclk), .wr_en(en),
        .addr(waddr), .data(wdata), .got(got), .rec(rec));
    task test_done;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One link clock period of 800 ns; the clock rests low between frames
    task tick(input logic d);
        sdi <= d;
        repeat (4) @(posedge core_clk);
        dr_clk <= 1'b1;
        repeat (4) @(posedge core_clk);
        dr_clk <= 1'b0;
    endtask
    task word(input logic [3:0] w, input int nb, input logic sh, input logic ok);
        logic [3:0] m;
        m = (emode == 2'h0) ? 4'hf : (emode == 2'h1) ? ering : (4'h1 << blk);
        shift <= sh;
        for (int i = 0; i < nb; i++)
            tick(w[i]);
        shift <= 1'b0;
        sdi <= ~w[nb-1];
        if (ok) begin
            notes.push_back({m, eaddr, w});
            if (eaddr == 2'h3 && emode == 2'h1)
                ering = {ering[2:0], ering[3]};
            eaddr = eaddr + 2'h1;
        end
        upd <= 1'b1;
        repeat (8) @(posedge core_clk);
        upd <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    // Passing through an idle opcode forces a fresh load on the next one
    task load(input logic [7:0] v, input logic [1:0] md, input logic fall);
        ir <= 8'h00;
        repeat (8) @(posedge core_clk);
        mode <= md;
        falling <= fall;
        repeat (8) @(posedge core_clk);
        ir <= v;
        repeat (10) @(posedge core_clk);
        eaddr = 2'h0;
        ering = 4'h1;
        emode = md;
        blk = v[1:0];
    endtask
    always @(posedge core_clk) begin
        if (got === 1'b1) begin
            if (notes.size() == 0) begin
                `CHK(rec, 10'h000, "stray write")
            end else begin
                exp_rec = notes.pop_front();
                `CHK(rec, exp_rec, "write")
            end
        end
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        arst_n <= 1'b0;
        dr_clk <= 1'b0;
        sdi <= 1'b0;
        shift <= 1'b0;
        upd <= 1'b0;
        ir <= 8'h00;
        mode <= 2'h0;
        falling <= 1'b0;
        void'($urandom(34440));
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK(en, 4'h0, "reset enables")
        `CHK(wclk, 1'b1, "idle write clock")
        load(8'h22, 2'h0, 1'b0);
        `CHK(active, 1'b1, "active")
        `CHK(ready, 1'b1, "ready")
        repeat (5) word(4'($urandom), 4, 1'b1, 1'b1);
        $display("test common done");
        word(4'($urandom), 3, 1'b1, 1'b0);
        word(4'($urandom), 4, 1'b0, 1'b0);
        word(4'($urandom), 4, 1'b1, 1'b1);
        $display("test dropped words done");
        load(8'h22, 2'h1, 1'b0);
        repeat (5) word(4'($urandom), 4, 1'b1, 1'b1);
        $display("test ring done");
        for (int b = 0; b < 4; b++) begin
            load(8'h30 + 8'(b), 2'h2, 1'b0);
            word(4'($urandom), 4, 1'b1, 1'b1);
        end
        $display("test opcode select done");
        load(8'h22, 2'h0, 1'b1);
        `CHK(wclk, 1'b0, "falling idle")
        word(4'($urandom), 4, 1'b1, 1'b1);
        $display("test falling edge done");
        load(8'h24, 2'h0, 1'b0);
        word(4'h2, 2, 1'b1, 1'b0);
        ir <= 8'h22;
        repeat (10) @(posedge core_clk);
        eaddr = 2'h2;
        repeat (2) word(4'($urandom), 4, 1'b1, 1'b1);
        $display("test address opcode done");
        load(8'h00, 2'h0, 1'b0);
        `CHK(active, 1'b0, "inactive")
        word(4'($urandom), 4, 1'b1, 1'b0);
        `CHK(notes.size(), 0, "pending writes")
        $display("test idle opcode done");
        test_done();
    end
endmodule // jri_loader_tb
